/* hdl/pdg_consts.svh */
// offsets, field positions, masks and reset values for the dead-time fault guard
`ifndef PDG_CONSTS_SVH
`define PDG_CONSTS_SVH
`define PDG_ADR_DT_CFG 4'h0
`define PDG_ADR_CUR_REF 4'h1
`define PDG_ADR_VOLT_REF 4'h2
`define PDG_ADR_PROT_EN 4'h3
`define PDG_ADR_PIN_DB 4'h4
`define PDG_ADR_AMP_TRIM 4'h5
`define PDG_ADR_VCMP_TRIM 4'h6
`define PDG_ADR_CCMP_TRIM 4'h7
`define PDG_ADR_CMP_OUT 4'h8
`define PDG_ADR_IRQ_FLAGS 4'h9
`define PDG_ADR_PAIR_CTL 4'hA
`define PDG_MASK_DT_CFG 8'h1F
`define PDG_MASK_VOLT_REF 8'h3F
`define PDG_MASK_PIN_DB 8'hEF
`define PDG_MASK_CMP_OUT 8'h07
`define PDG_MASK_IRQ 8'h03
`define PDG_MASK_PAIR 8'h03
`define PDG_RST_TRIM 8'h20
`define PDG_RST_ZERO 8'h00
`define PDG_DTP_LSB 3
`define PDG_DBV_LSB 0
`define PDG_DBC_LSB 2
`define PDG_BIT_CUR_MEN 7
`define PDG_BIT_VOLT_MEN 6
`define PDG_BIT_LO_CUR 5
`define PDG_BIT_HI_CUR 4
`define PDG_BIT_LO_VOLT 3
`define PDG_BIT_HI_VOLT 2
`define PDG_BIT_CUR_HYST 1
`define PDG_BIT_VOLT_HYST 0
`define PDG_BIT_AMP_POL 7
`define PDG_BIT_VPIN_EN 6
`define PDG_BIT_CPIN_EN 5
`define PDG_BIT_TRIM_MODE 7
`define PDG_BIT_TRIM_REF 6
`endif

/* hdl/pdg_guard.sv */
// dead-time insertion and fault gating for a complementary drive pair
// How it works
// - dead-time clock is clock divided 1/2/4/8
// - code n gives n+1 dead-time periods
// - dead time on rising edge, pair only
// - pair from timer1 pwm; high-side low-active
// - voltage fault when input exceeds 6-bit reference
// - current fault when input exceeds 8-bit reference
// - fault forces high-side high, low-side low
// - each fault event sets own flag
// - outputs follow pwm again when fault clears
// - current reference code is full byte
// - voltage reference code is 6-bit field
// - current master off disables current path
// - voltage master off disables voltage path
// - low-side current gate needs both enables
// - high-side current gate needs both enables
// - low-side voltage gate needs both enables
// - high-side voltage gate needs both enables
// - hysteresis enables for both comparators
// - amplifier mode bit selects polarity
// - pin-control bits enable sense pins
// - current debounce 0/16/32/64 clocks
// - amplifier trim mode bit
// - amplifier trim reference select bit
// - unimplemented bits read zero, ignore writes
//
// The address map and the Wishbone register port were left to the implementer.
`timescale 1ns/100ps
`include "pdg_consts.svh"
module pdg_guard (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [5:2] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic timer1_pwm_out_i,
   input wire logic volt_cmp_raw_i,
   input wire logic cur_cmp_raw_i,
   input wire logic amp_raw_i,
   output logic high_side_drive_o,
   output logic low_side_drive_o,
   output pdg_pkg::pdg_byte_t current_ref_code_o,
   output logic [5:0] voltage_ref_code_o,
   output pdg_pkg::pdg_byte_t analog_ctl_o,
   output pdg_pkg::pdg_byte_t amp_trim_o,
   output pdg_pkg::pdg_byte_t voltage_trim_o,
   output pdg_pkg::pdg_byte_t current_trim_o
);
   import pdg_pkg::*;

   pdg_byte_t dt_cfg_reg, cur_ref_reg, volt_ref_reg, prot_en_reg, pin_db_reg;
   pdg_byte_t amp_trim_reg, vtrim_reg, ctrim_reg, pair_reg, rd_next;
   logic [1:0] irq_reg;
   pdg_wb_state_t wb_reg;
   logic [2:0] vsync_reg, csync_reg, async_reg;
   logic vq_reg, cq_reg, vq_d_reg, cq_d_reg;
   pdg_cnt_t vcnt_reg, ccnt_reg;
   logic [2:0] pre_reg;
   logic [2:0] dcnt_reg;
   logic dt_busy_reg, pwm_d_reg, dt_tick, pwm_rise, dt_last;
   logic wr_hit, volt_on, cur_on, force_hi, force_lo, pair_both, hi_raw, lo_raw;

   // limit for debounce code: 00 none, else 2^(code+3)-1 clocks
   function automatic pdg_cnt_t db_limit(input logic [1:0] code);
      case (code)
         2'b01: db_limit = 6'd15;
         2'b10: db_limit = 6'd31;
         2'b11: db_limit = 6'd63;
         default: db_limit = 6'd0;
      endcase
   endfunction : db_limit

   // write merge honouring lane 0 and the implemented-bit mask
   function automatic pdg_byte_t wr_merge(input pdg_byte_t old, input pdg_byte_t msk,
                                          input logic en, input pdg_byte_t d);
      wr_merge = en ? (d & msk) : old;
   endfunction : wr_merge

   assign wr_hit = cyc_i && stb_i && we_i && sel_i[0] && (wb_reg == PDG_WB_IDLE) && ce_i;

   // wishbone slave: ack one cycle after request, then a one-cycle gap
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_reg <= PDG_WB_IDLE;
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end
      else if (ce_i)
      begin
         case (wb_reg)
            PDG_WB_IDLE:
            begin
               if (cyc_i && stb_i)
               begin
                  wb_reg <= PDG_WB_ACK;
                  ack_o <= 1'b1;
                  dat_o <= {24'h00_0000, rd_next};
               end
            end
            PDG_WB_ACK:
            begin
               wb_reg <= PDG_WB_DONE;
               ack_o <= 1'b0;
            end
            PDG_WB_DONE:
               wb_reg <= PDG_WB_IDLE;
            default:
            begin
               wb_reg <= PDG_WB_IDLE;
               ack_o <= 1'b0;
            end
         endcase
      end
   end

   always_comb
   begin
      case ({adr_i, 2'b00})
         {`PDG_ADR_DT_CFG, 2'b00}: rd_next = dt_cfg_reg;
         {`PDG_ADR_CUR_REF, 2'b00}: rd_next = cur_ref_reg;
         {`PDG_ADR_VOLT_REF, 2'b00}: rd_next = volt_ref_reg;
         {`PDG_ADR_PROT_EN, 2'b00}: rd_next = prot_en_reg;
         {`PDG_ADR_PIN_DB, 2'b00}: rd_next = pin_db_reg;
         {`PDG_ADR_AMP_TRIM, 2'b00}: rd_next = amp_trim_reg;
         {`PDG_ADR_VCMP_TRIM, 2'b00}: rd_next = vtrim_reg;
         {`PDG_ADR_CCMP_TRIM, 2'b00}: rd_next = ctrim_reg;
         {`PDG_ADR_CMP_OUT, 2'b00}: rd_next = {5'b0_0000, async_reg[2], csync_reg[2],
                                               vsync_reg[2]};
         {`PDG_ADR_IRQ_FLAGS, 2'b00}: rd_next = {6'b00_0000, irq_reg};
         {`PDG_ADR_PAIR_CTL, 2'b00}: rd_next = pair_reg;
         default: rd_next = `PDG_RST_ZERO;
      endcase
   end

   // configuration registers; masks drop unimplemented bits
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         dt_cfg_reg <= `PDG_RST_ZERO;
         cur_ref_reg <= `PDG_RST_ZERO;
         volt_ref_reg <= `PDG_RST_ZERO;
         prot_en_reg <= `PDG_RST_ZERO;
         pin_db_reg <= `PDG_RST_ZERO;
         amp_trim_reg <= `PDG_RST_TRIM;
         vtrim_reg <= `PDG_RST_TRIM;
         ctrim_reg <= `PDG_RST_TRIM;
         pair_reg <= `PDG_RST_ZERO;
      end
      else
      begin
         dt_cfg_reg <= wr_merge(dt_cfg_reg, `PDG_MASK_DT_CFG,
                                wr_hit && adr_i == `PDG_ADR_DT_CFG, dat_i[7:0]);
         cur_ref_reg <= wr_merge(cur_ref_reg, 8'hFF,
                                 wr_hit && adr_i == `PDG_ADR_CUR_REF, dat_i[7:0]);
         volt_ref_reg <= wr_merge(volt_ref_reg, `PDG_MASK_VOLT_REF,
                                  wr_hit && adr_i == `PDG_ADR_VOLT_REF, dat_i[7:0]);
         prot_en_reg <= wr_merge(prot_en_reg, 8'hFF,
                                 wr_hit && adr_i == `PDG_ADR_PROT_EN, dat_i[7:0]);
         pin_db_reg <= wr_merge(pin_db_reg, `PDG_MASK_PIN_DB,
                                wr_hit && adr_i == `PDG_ADR_PIN_DB, dat_i[7:0]);
         amp_trim_reg <= wr_merge(amp_trim_reg, 8'hFF,
                                  wr_hit && adr_i == `PDG_ADR_AMP_TRIM, dat_i[7:0]);
         vtrim_reg <= wr_merge(vtrim_reg, 8'hFF,
                               wr_hit && adr_i == `PDG_ADR_VCMP_TRIM, dat_i[7:0]);
         ctrim_reg <= wr_merge(ctrim_reg, 8'hFF,
                               wr_hit && adr_i == `PDG_ADR_CCMP_TRIM, dat_i[7:0]);
         pair_reg <= wr_merge(pair_reg, `PDG_MASK_PAIR,
                              wr_hit && adr_i == `PDG_ADR_PAIR_CTL, dat_i[7:0]);
      end
   end

   // master enables and pin enables gate each path
   assign cur_on = prot_en_reg[`PDG_BIT_CUR_MEN] && pin_db_reg[`PDG_BIT_CPIN_EN];
   assign volt_on = prot_en_reg[`PDG_BIT_VOLT_MEN] && pin_db_reg[`PDG_BIT_VPIN_EN];

   // three-flop synchronisers; stage 0 feeds stage 1 only
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         vsync_reg <= 3'b000;
         csync_reg <= 3'b000;
         async_reg <= 3'b000;
      end
      else if (ce_i)
      begin
         vsync_reg <= {vsync_reg[1], vsync_reg[0], volt_cmp_raw_i};
         csync_reg <= {csync_reg[1], csync_reg[0], cur_cmp_raw_i};
         async_reg <= {async_reg[1], async_reg[0], amp_raw_i};
      end
   end

   // voltage debounce: qualified level changes after stable run
   always_ff @(posedge clk_i)
   begin
      if (rst_i || !volt_on)
      begin
         vcnt_reg <= 6'd0;
         vq_reg <= 1'b0;
      end
      else if (ce_i)
      begin
         if (vsync_reg[2] == vq_reg)
            vcnt_reg <= 6'd0;
         else if (vcnt_reg >= db_limit(pin_db_reg[`PDG_DBV_LSB +: 2]))
         begin
            vq_reg <= vsync_reg[2];
            vcnt_reg <= 6'd0;
         end
         else
            vcnt_reg <= vcnt_reg + 6'd1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i || !cur_on)
      begin
         ccnt_reg <= 6'd0;
         cq_reg <= 1'b0;
      end
      else if (ce_i)
      begin
         if (csync_reg[2] == cq_reg)
            ccnt_reg <= 6'd0;
         else if (ccnt_reg >= db_limit(pin_db_reg[`PDG_DBC_LSB +: 2]))
         begin
            cq_reg <= csync_reg[2];
            ccnt_reg <= 6'd0;
         end
         else
            ccnt_reg <= ccnt_reg + 6'd1;
      end
   end

   // sticky flags, set wins over write-one-to-clear
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         vq_d_reg <= 1'b0;
         cq_d_reg <= 1'b0;
         irq_reg <= 2'b00;
      end
      else if (ce_i)
      begin
         vq_d_reg <= vq_reg;
         cq_d_reg <= cq_reg;
         irq_reg[0] <= (vq_reg && !vq_d_reg) ||
                       (irq_reg[0] && !(wr_hit && adr_i == `PDG_ADR_IRQ_FLAGS && dat_i[0]));
         irq_reg[1] <= (cq_reg && !cq_d_reg) ||
                       (irq_reg[1] && !(wr_hit && adr_i == `PDG_ADR_IRQ_FLAGS && dat_i[1]));
      end
   end

   // prescaler: tick every 1,2,4 or 8 clocks
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         pre_reg <= 3'd0;
      // restart on a pwm rising edge so the dead time is whole prescaled periods
      else if (ce_i && pwm_rise)
         pre_reg <= 3'd0;
      else if (ce_i)
         pre_reg <= pre_reg + 3'd1;
   end
   always_comb
   begin
      case (dt_cfg_reg[`PDG_DTP_LSB +: 2])
         2'b01: dt_tick = (pre_reg[0] == 1'b1);
         2'b10: dt_tick = (pre_reg[1:0] == 2'b11);
         2'b11: dt_tick = (pre_reg == 3'b111);
         default: dt_tick = 1'b1;
      endcase
   end

   // pair in use when both outputs selected
   assign pair_both = (pair_reg[1:0] == 2'b11);
   assign pwm_rise = pair_both && timer1_pwm_out_i && !pwm_d_reg;
   // last prescaled tick of the dead time
   assign dt_last = dt_busy_reg && dt_tick && (dcnt_reg == 3'd0);

   // dead-time counter restarted on every pwm rising edge while the pair is selected
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pwm_d_reg <= 1'b0;
         dt_busy_reg <= 1'b0;
         dcnt_reg <= 3'd0;
      end
      else if (ce_i)
      begin
         pwm_d_reg <= timer1_pwm_out_i;
         if (pwm_rise)
         begin
            dt_busy_reg <= 1'b1;
            dcnt_reg <= dt_cfg_reg[2:0];
         end
         else if (dt_busy_reg && dt_tick)
         begin
            if (dcnt_reg == 3'd0)
               dt_busy_reg <= 1'b0;
            else
               dcnt_reg <= dcnt_reg - 3'd1;
         end
      end
   end

   assign force_lo = (cq_reg && prot_en_reg[`PDG_BIT_LO_CUR]) ||
                     (vq_reg && prot_en_reg[`PDG_BIT_LO_VOLT]);
   assign force_hi = (cq_reg && prot_en_reg[`PDG_BIT_HI_CUR]) ||
                     (vq_reg && prot_en_reg[`PDG_BIT_HI_VOLT]);
   // high side active low; dead time holds it off from the rising edge itself
   // up to the last tick, so the gap is n+1 prescaled periods
   assign hi_raw = !(timer1_pwm_out_i && !pwm_rise && (!dt_busy_reg || dt_last));
   assign lo_raw = !timer1_pwm_out_i;

   // forced off levels while fault, pwm otherwise
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         high_side_drive_o <= 1'b1;
         low_side_drive_o <= 1'b0;
      end
      else if (ce_i)
      begin
         high_side_drive_o <= force_hi ? 1'b1 : hi_raw;
         low_side_drive_o <= force_lo ? 1'b0 : lo_raw;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         current_ref_code_o <= `PDG_RST_ZERO;
         voltage_ref_code_o <= 6'd0;
         analog_ctl_o <= `PDG_RST_ZERO;
         amp_trim_o <= `PDG_RST_TRIM;
         voltage_trim_o <= `PDG_RST_TRIM;
         current_trim_o <= `PDG_RST_TRIM;
      end
      else if (ce_i)
      begin
         current_ref_code_o <= cur_ref_reg;
         voltage_ref_code_o <= volt_ref_reg[5:0];
         analog_ctl_o <= {pin_db_reg[`PDG_BIT_AMP_POL], pin_db_reg[`PDG_BIT_VPIN_EN],
                          pin_db_reg[`PDG_BIT_CPIN_EN], 1'b0,
                          prot_en_reg[`PDG_BIT_CUR_MEN], prot_en_reg[`PDG_BIT_VOLT_MEN],
                          prot_en_reg[`PDG_BIT_CUR_HYST], prot_en_reg[`PDG_BIT_VOLT_HYST]};
         amp_trim_o <= amp_trim_reg;
         voltage_trim_o <= vtrim_reg;
         current_trim_o <= ctrim_reg;
      end
   end
endmodule : pdg_guard

/* hdl/pdg_pkg.sv */
// types for the dead-time fault guard
package pdg_pkg;
   typedef logic [7:0] pdg_byte_t;
   typedef logic [5:0] pdg_cnt_t;
   typedef enum logic [2:0] {
      PDG_WB_IDLE = 3'b001,
      PDG_WB_ACK = 3'b010,
      PDG_WB_DONE = 3'b100
   } pdg_wb_state_t;
endpackage : pdg_pkg

/* verif/pdg_analog_model.sv */
// analog comparator and amplifier stand-in driven by sensed levels
`timescale 1ns/100ps
module pdg_analog_model (
   input wire pdg_pkg::pdg_byte_t cur_lvl_i,
   input wire logic [5:0] volt_lvl_i,
   input wire pdg_pkg::pdg_byte_t cur_ref_i,
   input wire logic [5:0] volt_ref_i,
   output logic cur_cmp_raw_o,
   output logic volt_cmp_raw_o,
   output logic amp_raw_o
);
   import pdg_pkg::*;
   assign cur_cmp_raw_o = cur_lvl_i > cur_ref_i;
   assign volt_cmp_raw_o = volt_lvl_i > volt_ref_i;
   assign amp_raw_o = cur_lvl_i[0];
endmodule : pdg_analog_model

/* verif/pdg_guard_checker.sv */
// concurrent checks on the drive pair, read data and reference mirrors
`timescale 1ns/100ps
`include "pdg_consts.svh"
module pdg_guard_checker (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic we_i,
   input wire logic [5:2] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire logic timer1_pwm_out_i,
   input wire logic volt_cmp_raw_i,
   input wire logic cur_cmp_raw_i,
   input wire logic high_side_drive_o,
   input wire logic low_side_drive_o,
   input wire pdg_pkg::pdg_byte_t current_ref_code_o,
   input wire logic [5:0] voltage_ref_code_o,
   input wire pdg_pkg::pdg_byte_t analog_ctl_o
);
   import pdg_pkg::*;
   logic [6:0] quiet_reg;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // quiet cycles; 80 covers sync plus the longest debounce release
   always_ff @(posedge clk_i)
   begin
      if (rst_i || cur_cmp_raw_i || volt_cmp_raw_i)
         quiet_reg <= 7'h00;
      else if (quiet_reg != 7'h7F)
         quiet_reg <= quiet_reg + 7'h01;
   end
   chk_upper_zero: assert property (ack_o |-> dat_o[31:8] == 24'h00_0000)
      else $error("read data upper bits not zero");
   chk_no_overlap: assert property (!(!high_side_drive_o && low_side_drive_o))
      else $error("both transistors driven on");
   chk_hs_off_low: assert property (ce_i && !timer1_pwm_out_i |=> high_side_drive_o)
      else $error("high side on while pwm low");
   chk_ls_off_high: assert property (ce_i && timer1_pwm_out_i |=> !low_side_drive_o)
      else $error("low side on while pwm high");
   chk_ls_follows: assert property (ce_i && quiet_reg > 7'h50 |=>
      low_side_drive_o == !$past(timer1_pwm_out_i)) else $error("low side not following pwm");
   chk_masters_off: assert property (ce_i && !analog_ctl_o[3] && !analog_ctl_o[2] |=>
      low_side_drive_o == !$past(timer1_pwm_out_i)) else $error("guard acted while disabled");
   chk_cur_ref: assert property (ack_o && we_i && sel_i[0] && adr_i == `PDG_ADR_CUR_REF |=>
      current_ref_code_o == $past(dat_i[7:0])) else $error("current code not written");
   chk_volt_ref: assert property (ack_o && we_i && sel_i[0] &&
      adr_i == `PDG_ADR_VOLT_REF |=> voltage_ref_code_o == $past(dat_i[5:0]))
      else $error("voltage code not written");
endmodule : pdg_guard_checker

/* verif/tb_top.sv */
// self-checking bench for the dead-time fault guard
`timescale 1ns/100ps
module tb_top;
   import pdg_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i, ce_i, cyc_i, stb_i, we_i, timer1_pwm_out_i, ack_o;
   logic high_side_drive_o, low_side_drive_o, volt_cmp_raw_i, cur_cmp_raw_i, amp_raw_i;
   logic [5:2] adr_i;
   logic [3:0] sel_i;
   logic [31:0] dat_i, dat_o, q;
   logic [5:0] voltage_ref_code_o, volt_lvl;
   pdg_byte_t current_ref_code_o, analog_ctl_o, amp_trim_o, voltage_trim_o, current_trim_o;
   pdg_byte_t cur_lvl;
   int err_total, tests_run;
   pdg_byte_t rst_tab [11] = '{0: 8'h00, 5: 8'h20, 6: 8'h20, 7: 8'h20, default: 8'h00};
   pdg_byte_t msk_tab [8] = '{8'h1F, 8'hFF, 8'h3F, 8'hFF, 8'hEF, 8'hFF, 8'hFF, 8'hFF};
   logic [18:0] g_tab [9] = '{{8'hB0, 8'h20, 3'h7}, {8'hA0, 8'h20, 3'h6}, {8'hA0, 8'h20, 3'h3},
      {8'h30, 8'h20, 3'h2}, {8'hA0, 8'h00, 3'h2}, {8'h44, 8'h40, 3'h5}, {8'h48, 8'h40, 3'h1},
      {8'h0C, 8'h40, 3'h0}, {8'h48, 8'h40, 3'h4}};
   always #25 clk_i = ~clk_i;
   pdg_guard uut (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
      .dat_o, .ack_o, .timer1_pwm_out_i, .volt_cmp_raw_i, .cur_cmp_raw_i, .amp_raw_i,
      .high_side_drive_o, .low_side_drive_o, .current_ref_code_o, .voltage_ref_code_o,
      .analog_ctl_o, .amp_trim_o, .voltage_trim_o, .current_trim_o);
   pdg_analog_model far (.cur_lvl_i(cur_lvl), .volt_lvl_i(volt_lvl),
      .cur_ref_i(current_ref_code_o), .volt_ref_i(voltage_ref_code_o),
      .cur_cmp_raw_o(cur_cmp_raw_i), .volt_cmp_raw_o(volt_cmp_raw_i), .amp_raw_o(amp_raw_i));
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : final_report
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
         err_total++;
      end
   endtask : cmp
   task automatic cmp_rng(input string what, input int lo, input int hi, input int got);
      tests_run++;
      if (got < lo || got > hi)
      begin
         $display("MISMATCH %s expected %0d to %0d seen %0d", what, lo, hi, got);
         err_total++;
      end
   endtask : cmp_rng
   task automatic wb(input logic w, input logic [3:0] a, input pdg_byte_t d, input logic [3:0] s);
      int n;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      sel_i <= s;
      dat_i <= {24'h00_0000, d};
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 40);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
      if (n >= 40)
      begin
         err_total++;
         final_report;
      end
      repeat (2) @(posedge clk_i);
   endtask : wb
   task automatic wait_drive(input logic hi_side, input logic lvl, output int n);
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end while ((hi_side ? high_side_drive_o : low_side_drive_o) !== lvl && n < 300);
      if (n >= 300)
      begin
         err_total++;
         final_report;
      end
   endtask : wait_drive
   task automatic t_regs;
      for (int a = 0; a < 11; a++)
      begin
         wb(1'b0, a[3:0], 8'h00, 4'h1);
         cmp("reset value", rst_tab[a], q);
      end
      for (int a = 0; a < 8; a++)
         wb(1'b1, a[3:0], 8'hFF, 4'h1);
      for (int a = 0; a < 8; a++)
      begin
         wb(1'b0, a[3:0], 8'h00, 4'h1);
         cmp("masked readback", msk_tab[a], q);
      end
      wb(1'b1, 4'hB, 8'hFF, 4'h1);
      wb(1'b0, 4'hB, 8'h00, 4'h1);
      cmp("unmapped read", 0, q);
      wb(1'b1, 4'h1, 8'h00, 4'h0);
      cmp("current code", 8'hFF, current_ref_code_o);
      cmp("voltage code", 8'h3F, voltage_ref_code_o);
      cmp("analog control", 8'hEF, analog_ctl_o);
      cmp("amp trim", 8'hFF, amp_trim_o);
      cmp("voltage trim", 8'hFF, voltage_trim_o);
      cmp("current trim", 8'hFF, current_trim_o);
      for (int a = 0; a < 8; a++)
         wb(1'b1, a[3:0], 8'h00, 4'h1);
   endtask : t_regs
   task automatic t_dead;
      pdg_byte_t cfg [5] = '{8'h03, 8'h08, 8'h11, 8'h1F, 8'h1F};
      int n, t;
      for (int i = 0; i < 5; i++)
      begin
         wb(1'b1, 4'h0, cfg[i], 4'h1);
         wb(1'b1, 4'hA, i < 4 ? 8'h03 : 8'h00, 4'h1);
         t = (cfg[i][2:0] + 1) << cfg[i][4:3];
         timer1_pwm_out_i <= 1'b0;
         repeat (80) @(posedge clk_i);
         timer1_pwm_out_i <= 1'b1;
         wait_drive(1'b1, 1'b0, n);
         cmp_rng("dead time", i < 4 ? t + 1 : 2, i < 4 ? t + 2 : 2, n);
      end
      wb(1'b1, 4'hA, 8'h00, 4'h1);
   endtask : t_dead
   task automatic t_gate;
      logic [18:0] e;
      logic s;
      wb(1'b1, 4'h1, 8'h80, 4'h1);
      wb(1'b1, 4'h2, 8'h20, 4'h1);
      for (int i = 0; i < 9; i++)
      begin
         e = g_tab[i];
         wb(1'b1, 4'h3, e[18:11], 4'h1);
         wb(1'b1, 4'h4, e[10:3], 4'h1);
         timer1_pwm_out_i <= e[2];
         cur_lvl <= e[1] ? 8'h81 : 8'h00;
         volt_lvl <= e[1] ? 6'h00 : 6'h21;
         repeat (20) @(posedge clk_i);
         s = e[2] ? high_side_drive_o : low_side_drive_o;
         cmp("gated drive", e[2] ? e[0] : !e[0], s);
         if (e[0])
         begin
            wb(1'b0, 4'h9, 8'h00, 4'h1);
            cmp("event flag", e[1] ? 2 : 1, q);
            wb(1'b0, 4'h8, 8'h00, 4'h1);
            cmp("comparator state", e[1] ? 6 : 1, q);
         end
         cur_lvl <= 8'h00;
         volt_lvl <= 6'h00;
         repeat (20) @(posedge clk_i);
         cmp("recovered drive", !e[2], e[2] ? high_side_drive_o : low_side_drive_o);
         wb(1'b1, 4'h9, 8'h03, 4'h1);
         wb(1'b0, 4'h9, 8'h00, 4'h1);
         cmp("flag cleared", 0, q);
      end
   endtask : t_gate
   task automatic t_deb;
      int lim [4] = '{0, 15, 31, 63};
      int n;
      logic [1:0] d;
      timer1_pwm_out_i <= 1'b0;
      for (int k = 0; k < 8; k++)
      begin
         d = k[1:0];
         wb(1'b1, 4'h3, k < 4 ? 8'hA0 : 8'h48, 4'h1);
         wb(1'b1, 4'h4, k < 4 ? {4'h2, d, 2'b00} : {6'h10, d}, 4'h1);
         repeat (80) @(posedge clk_i);
         cur_lvl <= k < 4 ? 8'h81 : 8'h00;
         volt_lvl <= k < 4 ? 6'h00 : 6'h21;
         wait_drive(1'b0, 1'b0, n);
         cmp_rng("debounce delay", lim[d] + 3, lim[d] + 7, n);
         cur_lvl <= 8'h00;
         volt_lvl <= 6'h00;
         wait_drive(1'b0, 1'b1, n);
         wb(1'b1, 4'h9, 8'h03, 4'h1);
      end
   endtask : t_deb
   task automatic t_freeze;
      timer1_pwm_out_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      ce_i <= 1'b0;
      timer1_pwm_out_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      cmp("frozen low side", 1, low_side_drive_o);
      ce_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      cmp("resumed low side", 0, low_side_drive_o);
   endtask : t_freeze
   initial
   begin
      rst_i = 1'b1;
      {cyc_i, stb_i, we_i, timer1_pwm_out_i} = 4'h0;
      ce_i = 1'b1;
      adr_i = 4'h0;
      sel_i = 4'h0;
      dat_i = 32'h0000_0000;
      cur_lvl = 8'h00;
      volt_lvl = 6'h00;
      repeat (20) @(posedge clk_i);
      cmp("reset high side", 1, high_side_drive_o);
      cmp("reset low side", 0, low_side_drive_o);
      rst_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      t_regs;
      t_dead;
      t_gate;
      t_deb;
      t_freeze;
      final_report;
   end
endmodule : tb_top
bind pdg_guard pdg_guard_checker chk (.clk_i, .rst_i, .ce_i, .we_i, .adr_i, .sel_i, .dat_i,
   .dat_o, .ack_o, .timer1_pwm_out_i, .volt_cmp_raw_i, .cur_cmp_raw_i, .high_side_drive_o,
   .low_side_drive_o, .current_ref_code_o, .voltage_ref_code_o, .analog_ctl_o);
